// file: verilog/hub_cfg_pkg.sv
// constants, types and register map of the sensor hub configuration block
// Overview of operation
// - in source mode the first sensor's register named by the write-data byte is read first, and only a non-zero value lets the pointer read follow.
// - sensors two to four each hold a 7-bit target address in bits 7:1 and a read enable in bit 0, both reset to zero.
// - sensors two to four each hold an 8-bit register pointer, reset to zero, read only when that sensor's read enable is set.
// - bits 7:6 of each configuration set decimation from the hub trigger: every trigger, every 2, every 4 or every 8.
// - bits 2:0 of each configuration give the number of consecutive reads done on that sensor per hub cycle.
// - bit 5 of the second sensor's configuration makes the first sensor's write happen only in the first hub cycle instead of every cycle.
// - the one-shot write flag has effect only when the sensor count selects more than one sensor.
// - the write-data byte is what is written to the first sensor, or in source mode the register address read first.
// - the first sensor's direction bit selects write at 0 and read at 1.
// - the 2-bit sensor count services one sensor at 00 up to four at 11.
// - the source-mode bit enables the conditioned read at 1 and disables it at 0.
package hub_cfg_pkg;
   localparam logic [3:0] OFS_S1_ADDR = 4'h2;
   localparam logic [3:0] OFS_S1_PTR = 4'h3;
   localparam logic [3:0] OFS_S1_CFG = 4'h4;
   localparam logic [3:0] OFS_S2_ADDR = 4'h5;
   localparam logic [3:0] OFS_S2_PTR = 4'h6;
   localparam logic [3:0] OFS_S2_CFG = 4'h7;
   localparam logic [3:0] OFS_S3_ADDR = 4'h8;
   localparam logic [3:0] OFS_S3_PTR = 4'h9;
   localparam logic [3:0] OFS_S3_CFG = 4'hA;
   localparam logic [3:0] OFS_S4_ADDR = 4'hB;
   localparam logic [3:0] OFS_S4_PTR = 4'hC;
   localparam logic [3:0] OFS_S4_CFG = 4'hD;
   localparam logic [3:0] OFS_WDATA = 4'hE;
   localparam logic [3:0] OFS_STATUS = 4'hF;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int RATE_HI = 7;
   localparam int RATE_LO = 6;
   localparam int ONCE_BIT = 5;
   localparam int SRC_BIT = 3;
   localparam int CNT_HI = 5;
   localparam int CNT_LO = 4;
   localparam logic [2:0] DEC_RESET = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PICK = 3'b001,
      ST_ISSUE = 3'b010,
      ST_WAIT = 3'b011,
      ST_NEXT = 3'b100
   } hub_state_type;

   typedef enum logic [1:0] {
      OP_WRITE = 2'b00,
      OP_READ = 2'b01,
      OP_SRC_CHECK = 2'b10
   } op_kind_type;

   typedef struct packed {
      op_kind_type kind;
      logic [6:0] target;
      logic [7:0] reg_ptr;
      logic [7:0] wdata;
   } i2c_req_type;
endpackage

// file: verilog/sensor_hub_cfg.sv
// sensor hub configuration registers and per-cycle sequencer
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sensor_hub_cfg (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   input wire logic hub_trigger_i,
   output logic i2c_req_valid_o,
   output hub_cfg_pkg::i2c_req_type i2c_req_o,
   input wire logic i2c_done_i,
   input wire logic [7:0] i2c_rdata_i,
   output logic hub_busy_o
);
   logic [7:0] regs [2:14];
   logic answered;
   logic first_cycle_done;
   logic [2:0] dec_cnt;
   hub_cfg_pkg::hub_state_type state;
   logic [1:0] sensor_idx;
   logic [2:0] ops_left;
   logic src_pending;
   logic wr_sel;
   logic [3:0] word_idx;
   logic unmapped;

   function automatic logic [7:0] cfg_of(input logic [1:0] idx);
      cfg_of = regs[4 + 3 * idx];
   endfunction

   function automatic logic [7:0] addr_of(input logic [1:0] idx);
      addr_of = regs[2 + 3 * idx];
   endfunction

   function automatic logic [7:0] ptr_of(input logic [1:0] idx);
      ptr_of = regs[3 + 3 * idx];
   endfunction

   // decimation due when the trigger count is a multiple of 1, 2, 4 or 8
   function automatic logic rate_due(input logic [1:0] code, input logic [2:0] cnt);
      unique case (code)
         2'b00: rate_due = 1'b1;
         2'b01: rate_due = (cnt[0] == 1'b0);
         2'b10: rate_due = (cnt[1:0] == 2'b00);
         2'b11: rate_due = (cnt == 3'h0);
      endcase
   endfunction

   assign word_idx = avs_address_i[5:2];
   assign unmapped = (avs_address_i[1:0] != 2'b00) || (word_idx < hub_cfg_pkg::OFS_S1_ADDR);
   // write lands at the edge that sees waitrequest low, as the master expects
   assign wr_sel = avs_write_i && answered && !unmapped && avs_byteenable_i[0]
      && (word_idx != hub_cfg_pkg::OFS_STATUS);

   // one wait state per access: request seen, then answered
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         answered <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else begin
         answered <= (avs_read_i || avs_write_i) && !answered;
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !answered);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
         avs_response_o <= 2'b00;
      end else if ((avs_read_i || avs_write_i) && !answered) begin
         avs_response_o <= unmapped ? 2'b10 : 2'b00;
         if (!avs_read_i || unmapped) begin
            avs_readdata_o <= 32'h0000_0000;
         end else if (word_idx == hub_cfg_pkg::OFS_STATUS) begin
            avs_readdata_o <= {24'h00_0000, 1'b0, first_cycle_done, ops_left, state};
         end else begin
            avs_readdata_o <= {24'h00_0000, regs[word_idx]};
         end
      end
   end

   // bits held as written; keeping the must-be-zero bits clear is software's job
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 2; i <= 14; i++) begin
            regs[i] <= hub_cfg_pkg::REG_RESET;
         end
      end else if (wr_sel) begin
         regs[word_idx] <= avs_writedata_i[7:0];
      end
   end

   // trigger count for decimation; shared so all sensors align to trigger zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dec_cnt <= hub_cfg_pkg::DEC_RESET;
      end else if (hub_trigger_i && state == hub_cfg_pkg::ST_IDLE) begin
         dec_cnt <= dec_cnt + 3'h1;
      end
   end

   logic [7:0] cfg_cur;
   logic [7:0] s1_cfg;
   logic once_active;
   logic sensor_on;
   logic [7:0] cur_addr;
   logic [7:0] s1_addr;
   assign cfg_cur = cfg_of(sensor_idx);
   assign s1_cfg = regs[hub_cfg_pkg::OFS_S1_CFG];
   assign cur_addr = addr_of(sensor_idx);
   assign s1_addr = regs[hub_cfg_pkg::OFS_S1_ADDR];
   // one-shot only meaningful with more than one sensor
   assign once_active = regs[hub_cfg_pkg::OFS_S2_CFG][hub_cfg_pkg::ONCE_BIT]
      && (s1_cfg[hub_cfg_pkg::CNT_HI:hub_cfg_pkg::CNT_LO] != 2'b00);
   // sensor one needs no read enable; others need their read enable; all still gated by rate, and sensor one's write also by one-shot
   assign sensor_on = ((sensor_idx == 2'd0) || cur_addr[0])
      && rate_due(cfg_cur[hub_cfg_pkg::RATE_HI:hub_cfg_pkg::RATE_LO], dec_cnt)
      && !((sensor_idx == 2'd0) && !s1_addr[0] && once_active && first_cycle_done);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= hub_cfg_pkg::ST_IDLE;
         sensor_idx <= 2'd0;
         ops_left <= 3'h0;
         src_pending <= 1'b0;
         first_cycle_done <= 1'b0;
         i2c_req_valid_o <= 1'b0;
         i2c_req_o <= '0;
         hub_busy_o <= 1'b0;
      end else begin
         i2c_req_valid_o <= 1'b0;
         unique case (state)
            hub_cfg_pkg::ST_IDLE: begin
               if (hub_trigger_i) begin
                  sensor_idx <= 2'd0;
                  hub_busy_o <= 1'b1;
                  state <= hub_cfg_pkg::ST_PICK;
               end
            end
            hub_cfg_pkg::ST_PICK: begin
               if (sensor_on) begin
                  // a write is one operation; reads repeat numop times
                  ops_left <= ((sensor_idx == 2'd0) && !s1_addr[0])
                     ? 3'h1 : cfg_cur[2:0];
                  src_pending <= (sensor_idx == 2'd0) && s1_addr[0]
                     && s1_cfg[hub_cfg_pkg::SRC_BIT];
                  state <= hub_cfg_pkg::ST_ISSUE;
               end else begin
                  state <= hub_cfg_pkg::ST_NEXT;
               end
            end
            hub_cfg_pkg::ST_ISSUE: begin
               if (ops_left == 3'h0) begin
                  state <= hub_cfg_pkg::ST_NEXT;
               end else begin
                  i2c_req_valid_o <= 1'b1;
                  i2c_req_o.target <= cur_addr[7:1];
                  i2c_req_o.wdata <= regs[hub_cfg_pkg::OFS_WDATA];
                  if (src_pending) begin
                     i2c_req_o.kind <= hub_cfg_pkg::OP_SRC_CHECK;
                     i2c_req_o.reg_ptr <= regs[hub_cfg_pkg::OFS_WDATA];
                  end else begin
                     i2c_req_o.kind <= ((sensor_idx == 2'd0) && !s1_addr[0])
                        ? hub_cfg_pkg::OP_WRITE : hub_cfg_pkg::OP_READ;
                     i2c_req_o.reg_ptr <= ptr_of(sensor_idx);
                  end
                  state <= hub_cfg_pkg::ST_WAIT;
               end
            end
            hub_cfg_pkg::ST_WAIT: begin
               if (i2c_done_i) begin
                  if (src_pending) begin
                     src_pending <= 1'b0;
                     // zero content abandons the conditioned read
                     if (i2c_rdata_i == 8'h00) begin
                        ops_left <= 3'h0;
                     end
                  end else begin
                     ops_left <= ops_left - 3'h1;
                  end
                  state <= hub_cfg_pkg::ST_ISSUE;
               end
            end
            hub_cfg_pkg::ST_NEXT: begin
               // count field caps how many sensors are visited
               if (sensor_idx == s1_cfg[hub_cfg_pkg::CNT_HI:hub_cfg_pkg::CNT_LO]) begin
                  first_cycle_done <= 1'b1;
                  hub_busy_o <= 1'b0;
                  state <= hub_cfg_pkg::ST_IDLE;
               end else begin
                  sensor_idx <= sensor_idx + 2'd1;
                  state <= hub_cfg_pkg::ST_PICK;
               end
            end
            default: state <= hub_cfg_pkg::ST_IDLE;
         endcase
      end
   end

   property p_rst_regs;
      @(posedge ref_clk_i) $rose(rst_n_i) |-> regs[hub_cfg_pkg::OFS_S2_ADDR] == 8'h00
         && regs[hub_cfg_pkg::OFS_S2_PTR] == 8'h00 && regs[hub_cfg_pkg::OFS_WDATA] == 8'h00;
   endproperty
   a_rst_regs: assert property (p_rst_regs) else $error("register not zero after reset");

   property p_ptr_used;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      i2c_req_valid_o && i2c_req_o.kind == hub_cfg_pkg::OP_READ && sensor_idx != 2'd0
         |-> i2c_req_o.reg_ptr == ptr_of(sensor_idx) && cur_addr[0];
   endproperty
   a_ptr_used: assert property (p_ptr_used) else $error("read not from enabled pointer");

   property p_src_first;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      i2c_req_valid_o && i2c_req_o.kind == hub_cfg_pkg::OP_SRC_CHECK
         |-> i2c_req_o.reg_ptr == regs[hub_cfg_pkg::OFS_WDATA] && sensor_idx == 2'd0;
   endproperty
   a_src_first: assert property (p_src_first) else $error("source check uses wrong address");

   sequence s_src_zero;
      state == hub_cfg_pkg::ST_WAIT && src_pending && i2c_done_i && i2c_rdata_i == 8'h00;
   endsequence
   property p_src_abort;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_src_zero |=> ops_left == 3'h0 ##1 !i2c_req_valid_o;
   endproperty
   a_src_abort: assert property (p_src_abort) else $error("zero source value not abandoned");

   property p_src_only;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      i2c_req_valid_o && i2c_req_o.kind == hub_cfg_pkg::OP_SRC_CHECK
         |-> $past(s1_cfg[hub_cfg_pkg::SRC_BIT], 2);
   endproperty
   a_src_only: assert property (p_src_only) else $error("source check without source mode");

   property p_write_kind;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      i2c_req_valid_o && i2c_req_o.kind == hub_cfg_pkg::OP_WRITE
         |-> sensor_idx == 2'd0 && !s1_addr[0]
            && i2c_req_o.wdata == regs[hub_cfg_pkg::OFS_WDATA];
   endproperty
   a_write_kind: assert property (p_write_kind) else $error("write issued wrongly");

   property p_count_cap;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_NEXT
         && sensor_idx == s1_cfg[hub_cfg_pkg::CNT_HI:hub_cfg_pkg::CNT_LO]
         && !wr_sel |=> state == hub_cfg_pkg::ST_IDLE && !hub_busy_o;
   endproperty
   a_count_cap: assert property (p_count_cap) else $error("hub cycle overran count");

   property p_order;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_NEXT && state != $past(state) ##1 state == hub_cfg_pkg::ST_PICK
         |-> sensor_idx == $past(sensor_idx, 1) + 2'd1;
   endproperty
   a_order: assert property (p_order) else $error("sensors out of order");

   property p_once;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      i2c_req_valid_o && i2c_req_o.kind == hub_cfg_pkg::OP_WRITE |-> !(once_active && first_cycle_done);
   endproperty
   a_once: assert property (p_once) else $error("one-shot write repeated");

   // answer one cycle after the request is first seen
   property p_wait_answer;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (avs_read_i || avs_write_i) && !answered |=> !avs_waitrequest_o;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("waitrequest not released");

   property p_wait_pulse;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

   property p_wdata_set;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_sel && word_idx == hub_cfg_pkg::OFS_WDATA
         |=> regs[hub_cfg_pkg::OFS_WDATA] == $past(avs_writedata_i[7:0]);
   endproperty
   a_wdata_set: assert property (p_wdata_set) else $error("write data not stored");

   property p_skip_off;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_PICK && sensor_idx != 2'd0 && !cur_addr[0]
         |=> state == hub_cfg_pkg::ST_NEXT;
   endproperty
   a_skip_off: assert property (p_skip_off) else $error("disabled sensor read");

   property p_rate_half;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_PICK && dec_cnt[0]
         && cfg_cur[hub_cfg_pkg::RATE_HI:hub_cfg_pkg::RATE_LO] == 2'b01
         |=> state == hub_cfg_pkg::ST_NEXT;
   endproperty
   a_rate_half: assert property (p_rate_half) else $error("read not decimated");

   property p_rate_s4;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_PICK && sensor_idx == 2'd3 && dec_cnt[1:0] != 2'b00
         && cfg_cur[hub_cfg_pkg::RATE_HI:hub_cfg_pkg::RATE_LO] == 2'b10
         |=> state == hub_cfg_pkg::ST_NEXT;
   endproperty
   a_rate_s4: assert property (p_rate_s4) else $error("sensor four rate wrong");

   property p_read_count;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_PICK && sensor_on && sensor_idx != 2'd0
         |=> ops_left == $past(cfg_cur[2:0]);
   endproperty
   a_read_count: assert property (p_read_count) else $error("read count not loaded");

   sequence s_read_done;
      state == hub_cfg_pkg::ST_WAIT && i2c_done_i && !src_pending;
   endsequence
   property p_read_step;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_read_done |=> ops_left == $past(ops_left) - 3'h1 && state == hub_cfg_pkg::ST_ISSUE;
   endproperty
   a_read_step: assert property (p_read_step) else $error("read count not stepped");

   // single sensor: one-shot flag ignored, write goes out every cycle
   property p_solo_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_PICK && sensor_idx == 2'd0 && !s1_addr[0]
         && s1_cfg[hub_cfg_pkg::CNT_HI:hub_cfg_pkg::CNT_LO] == 2'b00
         && cfg_cur[hub_cfg_pkg::RATE_HI:hub_cfg_pkg::RATE_LO] == 2'b00
         |=> state == hub_cfg_pkg::ST_ISSUE && ops_left == 3'h1;
   endproperty
   a_solo_write: assert property (p_solo_write) else $error("lone sensor write lost");

   property p_start;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      state == hub_cfg_pkg::ST_IDLE && hub_trigger_i
         |=> hub_busy_o && state == hub_cfg_pkg::ST_PICK && sensor_idx == 2'd0;
   endproperty
   a_start: assert property (p_start) else $error("hub cycle start wrong");

   sequence s_src_nonzero;
      state == hub_cfg_pkg::ST_WAIT && src_pending && i2c_done_i && i2c_rdata_i != 8'h00;
   endsequence
   property p_src_pass;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_src_nonzero ##1 ops_left != 3'h0 |=> i2c_req_valid_o
         && i2c_req_o.kind == hub_cfg_pkg::OP_READ
         && i2c_req_o.reg_ptr == regs[hub_cfg_pkg::OFS_S1_PTR];
   endproperty
   a_src_pass: assert property (p_src_pass) else $error("source read not followed");
endmodule
`default_nettype wire

// file: tb/sensor_bus_model.sv
// behavioural external sensor bus answering hub requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module sensor_bus_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input wire hub_cfg_pkg::i2c_req_type req_i,
   input wire logic [7:0] check_value_i,
   input wire logic [3:0] delay_i,
   output logic done_o,
   output logic [7:0] rdata_o
);
   logic [4:0] wait_cnt;
   logic pending;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending <= 1'b0;
         wait_cnt <= 5'h00;
         done_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         // data churns outside answers so a stale byte never looks valid
         rdata_o <= rdata_o + 8'h3B;
         if (req_valid_i) begin
            pending <= 1'b1;
            wait_cnt <= 5'h00;
         end else if (pending && wait_cnt >= {1'b0, delay_i}) begin
            pending <= 1'b0;
            done_o <= 1'b1;
            if (req_i.kind == hub_cfg_pkg::OP_SRC_CHECK) begin
               rdata_o <= check_value_i;
            end else begin
               rdata_o <= req_i.reg_ptr;
            end
         end else begin
            wait_cnt <= wait_cnt + 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the sensor hub configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk;
   logic rst_n = 1'b0;
   logic [5:0] addr = 6'h00;
   logic rd = 1'b0;
   logic wr_en = 1'b0;
   logic [3:0] be = 4'hF;
   logic [31:0] wdat = 32'h00000000;
   logic trig = 1'b0;
   logic [7:0] cv = 8'h00;
   logic [3:0] dly = 4'h0;
   logic done;
   logic [7:0] rdat;
   logic [31:0] rdo;
   logic wait_o;
   logic [1:0] resp;
   logic valid_o;
   logic busy_o;
   hub_cfg_pkg::i2c_req_type req_o;
   hub_cfg_pkg::i2c_req_type req_log[$];
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   sensor_hub_cfg u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr_en), .avs_byteenable_i(be), .avs_writedata_i(wdat),
      .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o), .avs_response_o(resp),
      .hub_trigger_i(trig), .i2c_req_valid_o(valid_o), .i2c_req_o(req_o),
      .i2c_done_i(done), .i2c_rdata_i(rdat), .hub_busy_o(busy_o));
   sensor_bus_model u_bus (.clk_i(clk), .rst_n_i(rst_n), .req_valid_i(valid_o),
      .req_i(req_o), .check_value_i(cv), .delay_i(dly), .done_o(done), .rdata_o(rdat));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (valid_o === 1'b1) req_log.push_back(req_o);
      cycles++;
      // whole run needs under a thousand cycles
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      @(posedge clk);
      addr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      wr_en <= w;
      rd <= !w;
      // waits for the answer; only the bench timeout ends a hang
      do begin
         @(posedge clk);
      end while (wait_o !== 1'b0);
      q = rdo;
      r = resp;
      wr_en <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, idx, d, q, r);
   endtask
   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input logic [1:0] er);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, idx, 8'h00, q, r);
      chk("readdata", {24'h000000, exp}, q);
      chk("response", {30'h0, er}, {30'h0, r});
   endtask
   task automatic cfg_s(input logic [3:0] n, input logic [7:0] a, input logic [7:0] p,
                        input logic [7:0] c);
      wr(4'h2 + 4'h3 * n, a);
      wr(4'h3 + 4'h3 * n, p);
      wr(4'h4 + 4'h3 * n, c);
   endtask
   task automatic hub_cycle(input int exp_n);
      int n;
      n = 0;
      req_log.delete();
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (2) @(posedge clk);
      while (busy_o !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("hub_finished", 32'h0, {31'h0, busy_o});
      chk("request_count", exp_n, req_log.size());
   endtask
   task automatic chk_req(input int i, input logic [1:0] k, input logic [6:0] t,
                          input logic [7:0] p);
      hub_cfg_pkg::i2c_req_type e;
      e = (req_log.size() > i) ? req_log[i] : '1;
      chk("request", {8'h00, k, t, p}, {8'h00, e.kind, e.target, e.reg_ptr});
   endtask

   task automatic t_regs();
      for (int i = 5; i < 15; i++) rd_chk(i[3:0], 8'h00, 2'b00);
      rd_chk(4'h0, 8'h00, 2'b10);
      wr(4'hF, 8'hFF);
      rd_chk(4'hF, 8'h00, 2'b00);
      // values keep the must-be-zero configuration bits clear
      for (int i = 5; i < 15; i++) wr(i[3:0], {1'b1, i[3], 3'b000, i[2:0]});
      for (int i = 5; i < 15; i++) rd_chk(i[3:0], {1'b1, i[3], 3'b000, i[2:0]}, 2'b00);
   endtask
   task automatic t_order();
      cfg_s(4'h0, {7'h11, 1'b1}, 8'h31, 8'h31);
      cfg_s(4'h1, {7'h12, 1'b1}, 8'h32, 8'h02);
      cfg_s(4'h2, {7'h13, 1'b0}, 8'h33, 8'h01);
      cfg_s(4'h3, {7'h14, 1'b1}, 8'h34, 8'h01);
      hub_cycle(4);
      chk_req(0, hub_cfg_pkg::OP_READ, 7'h11, 8'h31);
      chk_req(1, hub_cfg_pkg::OP_READ, 7'h12, 8'h32);
      chk_req(2, hub_cfg_pkg::OP_READ, 7'h12, 8'h32);
      chk_req(3, hub_cfg_pkg::OP_READ, 7'h14, 8'h34);
      rd_chk(4'hF, 8'h40, 2'b00);
   endtask
   task automatic t_once();
      do_reset();
      cfg_s(4'h0, {7'h11, 1'b0}, 8'h31, 8'h10);
      cfg_s(4'h1, {7'h12, 1'b0}, 8'h32, 8'h20);
      wr(4'hE, 8'h5A);
      hub_cycle(1);
      chk_req(0, hub_cfg_pkg::OP_WRITE, 7'h11, 8'h31);
      chk("write_data", 32'h5A, {24'h0, req_log[0].wdata});
      hub_cycle(0);
      wr(4'h4, 8'h00);
      hub_cycle(1);
      hub_cycle(1);
   endtask
   task automatic t_src();
      cfg_s(4'h0, {7'h11, 1'b1}, 8'h31, 8'h09);
      wr(4'hE, 8'h42);
      dly <= 4'h5;
      cv <= 8'h00;
      hub_cycle(1);
      chk_req(0, hub_cfg_pkg::OP_SRC_CHECK, 7'h11, 8'h42);
      cv <= 8'h07;
      hub_cycle(2);
      chk_req(1, hub_cfg_pkg::OP_READ, 7'h11, 8'h31);
      dly <= 4'h0;
   endtask
   task automatic t_decim();
      int seen[4];
      int per_trig[8];
      seen = '{0, 0, 0, 0};
      // trigger count restarts at zero and steps on each trigger, so trigger k sees count (k+1) mod 8
      per_trig = '{0, 1, 0, 2, 0, 1, 0, 3};
      do_reset();
      cfg_s(4'h0, {7'h11, 1'b1}, 8'h31, 8'h30);
      cfg_s(4'h1, {7'h12, 1'b1}, 8'h32, 8'h41);
      cfg_s(4'h2, {7'h13, 1'b1}, 8'h33, 8'hC1);
      cfg_s(4'h3, {7'h14, 1'b1}, 8'h34, 8'h81);
      // eight triggers cover every phase of the shared decimation count
      for (int c = 0; c < 8; c++) begin
         hub_cycle(per_trig[c]);
         foreach (req_log[i]) seen[req_log[i].target[1:0]]++;
      end
      chk("sensor1_reads", 0, seen[1]);
      chk("sensor2_reads", 4, seen[2]);
      chk("sensor3_reads", 1, seen[3]);
      chk("sensor4_reads", 2, seen[0]);
   endtask

   initial begin
      do_reset();
      t_regs();
      t_order();
      t_once();
      t_src();
      t_decim();
      conclude();
   end
endmodule
`default_nettype wire
